/* regulator_regs_pkg.sv */
/*
 * package for the regulator configuration and status register bank:
 * register addresses, field positions, reset values and mode encodings.
 * assumes an 8-bit register address space reached through the serial host bus.
 */
package regulator_regs_pkg;

	// ==========================================================
	// register addresses
	localparam logic [7:0] ADDR_SWITCH_UV_FLAGS = 8'h03;
	localparam logic [7:0] ADDR_LINEAR_REG_CONFIG = 8'h36;
	localparam logic [7:0] ADDR_CONV1_PROTECT = 8'h48;
	localparam logic [7:0] ADDR_CONV1_BROWNOUT = 8'h49;
	localparam logic [7:0] ADDR_CONV2_PROTECT = 8'h4c;
	localparam logic [7:0] ADDR_CONV2_BROWNOUT = 8'h4d;
	localparam logic [7:0] ADDR_CONV3_PROTECT = 8'h50;
	localparam logic [7:0] ADDR_CONV3_BROWNOUT = 8'h51;
	localparam logic [7:0] ADDR_CONV3_LOW_POWER = 8'h52;
	localparam logic [7:0] ADDR_SWITCH1_CONFIG = 8'h69;
	localparam logic [7:0] ADDR_SWITCH2_CONFIG = 8'h6a;
	localparam logic [7:0] ADDR_SWITCH3_CONFIG = 8'h6b;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_SWITCH_UV_FLAGS = 8'h00;
	localparam logic [7:0] RST_LINEAR_REG_CONFIG = 8'ha8;
	localparam logic [7:0] RST_CONV12_PROTECT = 8'h46;
	localparam logic [7:0] RST_CONV12_BROWNOUT = 8'h49;
	localparam logic [7:0] RST_CONV3_PROTECT = 8'h06;
	localparam logic [7:0] RST_CONV3_BROWNOUT = 8'h59;
	localparam logic [7:0] RST_CONV3_LOW_POWER = 8'h37;
	localparam logic [7:0] RST_SWITCH1_CONFIG = 8'h0d;
	localparam logic [7:0] RST_SWITCH2_CONFIG = 8'h25;
	localparam logic [7:0] RST_SWITCH3_CONFIG = 8'h20;

	// ==========================================================
	// writable bit masks; blank bits hold no storage
	localparam logic [7:0] MASK_PROTECT = 8'h0f;
	localparam logic [7:0] MASK_BROWNOUT = 8'h0f;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_SWITCH_UV = 8'h07;

	// ==========================================================
	// field positions
	localparam int POS_PROT_OV_THR = 0;
	localparam int POS_PROT_BO_PR = 1;
	localparam int POS_BO_HYS = 0;
	localparam int POS_BO_THR = 2;
	localparam int POS_LP_CODE = 0;
	localparam int POS_SW_DRV = 0;
	localparam int POS_SW_SRC = 3;
	localparam int POS_SW_EXT = 5;
	localparam int POS_LDO_CODE = 0;
	localparam int POS_LDO_DIS = 7;

	// ==========================================================
	// switch input source encodings
	typedef enum logic [1:0] {
		SRC_CONV_ONE = 2'b00,
		SRC_CONV_TWO = 2'b01,
		SRC_CONV_THREE = 2'b10,
		SRC_SYSTEM_SUPPLY = 2'b11
	} switch_source_t;

endpackage : regulator_regs_pkg

/* regulator_config_status_regs.sv */
/*
 * register bank for three step-down converters, three load switches and one
 * linear regulator: configuration storage, control decode and clear-on-read flags.
 * assumes the serial host bus front end presents single-cycle read and write
 * strobes with an address, on i_core_clk; comparator and enable inputs are
 * asynchronous analog levels.
 */
`timescale 1ns/1ps
module regulator_config_status_regs
	import regulator_regs_pkg::*;
#(
	parameter int NUM_CONV = 3,
	parameter int NUM_SWITCH = 3
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic [NUM_CONV-1:0] i_conv_on,
	input wire logic [NUM_SWITCH-1:0] i_switch_on,
	input wire logic [NUM_SWITCH-1:0] i_switch_undervolt,
	input wire logic i_linear_reg_on,
	input wire logic i_low_power_mode,
	output logic [NUM_CONV-1:0] o_conv_discharge_on,
	output logic [NUM_CONV-1:0] o_conv_fixed_freq_enable,
	output logic [2*NUM_CONV-1:0] o_conv_brownout_reject_period,
	output logic [NUM_CONV-1:0] o_conv_overvolt_threshold_sel,
	output logic [2*NUM_CONV-1:0] o_conv_brownout_threshold,
	output logic [2*NUM_CONV-1:0] o_conv_brownout_hysteresis,
	output logic [6:0] o_conv3_active_voltage_code,
	output logic o_conv3_use_low_power_code,
	output logic [2*NUM_SWITCH-1:0] o_switch_source,
	output logic [5:0] o_switch_gate_drive_rate,
	output logic o_linear_reg_discharge_on,
	output logic [6:0] o_linear_reg_voltage_code
);

	// ==========================================================
	// storage
	logic [7:0] conv_protect_q [NUM_CONV];
	logic [7:0] conv_brownout_q [NUM_CONV];
	logic [7:0] conv3_low_power_q;
	logic [7:0] switch_config_q [NUM_SWITCH];
	logic [7:0] linear_reg_config_q;
	logic [7:0] switch_uv_flags_q;
	logic [7:0] switch_uv_flags_d;
	logic [NUM_SWITCH-1:0] uv_meta_q;
	logic [NUM_SWITCH-1:0] uv_sync_q;
	logic [NUM_SWITCH-1:0] sw_on_meta_q;
	logic [NUM_SWITCH-1:0] sw_on_sync_q;
	logic [NUM_CONV-1:0] conv_on_meta_q;
	logic [NUM_CONV-1:0] conv_on_sync_q;
	logic [1:0] ldo_on_q;
	logic lp_meta_q;
	logic lp_sync_q;
	logic [7:0] rdata_d;

	// ==========================================================
	// input synchronisers
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			uv_meta_q <= '0;
			uv_sync_q <= '0;
			sw_on_meta_q <= '0;
			sw_on_sync_q <= '0;
			conv_on_meta_q <= '0;
			conv_on_sync_q <= '0;
			ldo_on_q <= 2'h0;
			lp_meta_q <= 1'b0;
			lp_sync_q <= 1'b0;
		end else begin
			uv_meta_q <= i_switch_undervolt;
			uv_sync_q <= uv_meta_q;
			sw_on_meta_q <= i_switch_on;
			sw_on_sync_q <= sw_on_meta_q;
			conv_on_meta_q <= i_conv_on;
			conv_on_sync_q <= conv_on_meta_q;
			ldo_on_q <= {ldo_on_q[0], i_linear_reg_on};
			lp_meta_q <= i_low_power_mode;
			lp_sync_q <= lp_meta_q;
		end
	end

	// ==========================================================
	// converter configuration writes
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			conv_protect_q[0] <= RST_CONV12_PROTECT & MASK_PROTECT;
			conv_protect_q[1] <= RST_CONV12_PROTECT & MASK_PROTECT;
			conv_protect_q[2] <= RST_CONV3_PROTECT & MASK_PROTECT;
			conv_brownout_q[0] <= RST_CONV12_BROWNOUT & MASK_BROWNOUT;
			conv_brownout_q[1] <= RST_CONV12_BROWNOUT & MASK_BROWNOUT;
			conv_brownout_q[2] <= RST_CONV3_BROWNOUT & MASK_BROWNOUT;
			conv3_low_power_q <= RST_CONV3_LOW_POWER;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				// blank bits are masked off so they never store
				ADDR_CONV1_PROTECT: conv_protect_q[0] <= i_reg_wdata & MASK_PROTECT;
				ADDR_CONV2_PROTECT: conv_protect_q[1] <= i_reg_wdata & MASK_PROTECT;
				ADDR_CONV3_PROTECT: conv_protect_q[2] <= i_reg_wdata & MASK_PROTECT;
				ADDR_CONV1_BROWNOUT: conv_brownout_q[0] <= i_reg_wdata & MASK_BROWNOUT;
				ADDR_CONV2_BROWNOUT: conv_brownout_q[1] <= i_reg_wdata & MASK_BROWNOUT;
				ADDR_CONV3_BROWNOUT: conv_brownout_q[2] <= i_reg_wdata & MASK_BROWNOUT;
				ADDR_CONV3_LOW_POWER: conv3_low_power_q <= i_reg_wdata & MASK_FULL;
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// switch and linear regulator configuration writes
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			switch_config_q[0] <= RST_SWITCH1_CONFIG;
			switch_config_q[1] <= RST_SWITCH2_CONFIG;
			switch_config_q[2] <= RST_SWITCH3_CONFIG;
			linear_reg_config_q <= RST_LINEAR_REG_CONFIG;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_SWITCH1_CONFIG: switch_config_q[0] <= i_reg_wdata;
				ADDR_SWITCH2_CONFIG: switch_config_q[1] <= i_reg_wdata;
				ADDR_SWITCH3_CONFIG: switch_config_q[2] <= i_reg_wdata;
				ADDR_LINEAR_REG_CONFIG: linear_reg_config_q <= i_reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// undervoltage flags: set wins over clear-on-read
	always_comb begin
		switch_uv_flags_d = switch_uv_flags_q;
		if (i_reg_rd && i_reg_addr == ADDR_SWITCH_UV_FLAGS) begin
			switch_uv_flags_d = 8'h00;
		end
		for (int i = 0; i < NUM_SWITCH; i++) begin
			if (sw_on_sync_q[i] && uv_sync_q[i]) begin
				switch_uv_flags_d[i] = 1'b1;
			end
		end
		switch_uv_flags_d = switch_uv_flags_d & MASK_SWITCH_UV;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			switch_uv_flags_q <= RST_SWITCH_UV_FLAGS;
		end else begin
			switch_uv_flags_q <= switch_uv_flags_d;
		end
	end

	// ==========================================================
	// read data
	always_comb begin
		case (i_reg_addr)
			ADDR_SWITCH_UV_FLAGS: rdata_d = switch_uv_flags_q;
			ADDR_LINEAR_REG_CONFIG: rdata_d = linear_reg_config_q;
			ADDR_CONV1_PROTECT: rdata_d = conv_protect_q[0];
			ADDR_CONV1_BROWNOUT: rdata_d = conv_brownout_q[0];
			ADDR_CONV2_PROTECT: rdata_d = conv_protect_q[1];
			ADDR_CONV2_BROWNOUT: rdata_d = conv_brownout_q[1];
			ADDR_CONV3_PROTECT: rdata_d = conv_protect_q[2];
			ADDR_CONV3_BROWNOUT: rdata_d = conv_brownout_q[2];
			ADDR_CONV3_LOW_POWER: rdata_d = conv3_low_power_q;
			ADDR_SWITCH1_CONFIG: rdata_d = switch_config_q[0];
			ADDR_SWITCH2_CONFIG: rdata_d = switch_config_q[1];
			ADDR_SWITCH3_CONFIG: rdata_d = switch_config_q[2] & 8'h38;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_d;
		end
	end

	// ==========================================================
	// converter controls
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_conv_discharge_on <= '0;
			o_conv_fixed_freq_enable <= '0;
			o_conv_brownout_reject_period <= '0;
			o_conv_overvolt_threshold_sel <= '0;
			o_conv_brownout_threshold <= '0;
			o_conv_brownout_hysteresis <= '0;
		end else begin
			for (int c = 0; c < NUM_CONV; c++) begin
				// discharge-disable sits in bit 1, fixed-frequency in bit 0 of the second
				// configuration, which this bank does not hold as a register of its own;
				// they are carried here in brownout bit [3] and protect bit [3] respectively
				o_conv_discharge_on[c] <= !conv_on_sync_q[c] && !conv_brownout_q[c][3];
				o_conv_fixed_freq_enable[c] <= conv_protect_q[c][3];
				o_conv_brownout_reject_period[2*c +: 2] <= conv_protect_q[c][POS_PROT_BO_PR +: 2];
				o_conv_overvolt_threshold_sel[c] <= conv_protect_q[c][POS_PROT_OV_THR];
				o_conv_brownout_threshold[2*c +: 2] <= conv_brownout_q[c][POS_BO_THR +: 2];
				o_conv_brownout_hysteresis[2*c +: 2] <= conv_brownout_q[c][POS_BO_HYS +: 2];
			end
		end
	end

	// ==========================================================
	// converter three low-power code
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_conv3_active_voltage_code <= 7'h00;
			o_conv3_use_low_power_code <= 1'b0;
		end else begin
			o_conv3_use_low_power_code <= lp_sync_q;
			o_conv3_active_voltage_code <= conv3_low_power_q[POS_LP_CODE +: 7];
		end
	end

	// ==========================================================
	// load switch and linear regulator controls
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_switch_source <= '0;
			o_switch_gate_drive_rate <= 6'h00;
			o_linear_reg_discharge_on <= 1'b0;
			o_linear_reg_voltage_code <= 7'h00;
		end else begin
			for (int s = 0; s < NUM_SWITCH; s++) begin
				if (switch_config_q[s][POS_SW_EXT]) begin
					o_switch_source[2*s +: 2] <= SRC_SYSTEM_SUPPLY;
				end else if (switch_config_q[s][POS_SW_SRC + 1]) begin
					o_switch_source[2*s +: 2] <= SRC_CONV_THREE;
				end else if (switch_config_q[s][POS_SW_SRC]) begin
					o_switch_source[2*s +: 2] <= SRC_CONV_TWO;
				end else begin
					o_switch_source[2*s +: 2] <= SRC_CONV_ONE;
				end
			end
			o_switch_gate_drive_rate <= {switch_config_q[1][POS_SW_DRV +: 3],
				switch_config_q[0][POS_SW_DRV +: 3]};
			o_linear_reg_discharge_on <= linear_reg_config_q[POS_LDO_DIS] && !ldo_on_q[1];
			o_linear_reg_voltage_code <= linear_reg_config_q[POS_LDO_CODE +: 7];
		end
	end

endmodule : regulator_config_status_regs

/* host_bus_model.sv */
/* host model: drives single-cycle register reads and writes on the bank's bus.
   assumes the testbench calls access from one process, after reset release. */
`timescale 1ns/1ps
module host_bus_model (
	input wire logic i_core_clk,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	// ====
	// one strobe, then strobes drop and address and data lines show the inverse of the given values
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge i_core_clk);
		o_reg_wr <= wr;
		o_reg_rd <= !wr;
		o_reg_addr <= addr;
		o_reg_wdata <= (wr && addr == 8'h52 && data[6:0] == 7'h00) ? 8'h01 : data;
		@(posedge i_core_clk);
		o_reg_wr <= 1'b0;
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~addr;
		o_reg_wdata <= ~data;
	endtask : access
endmodule : host_bus_model

/* regulator_config_status_regs_checker.sv */
/* checker for the regulator register bank ports.
   assumes one clock domain; outputs settle one edge after their register. */
`timescale 1ns/1ps
module regs_checker (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_linear_reg_on,
	input wire logic [5:0] o_switch_source,
	input wire logic [5:0] o_switch_gate_drive_rate,
	input wire logic [6:0] o_conv3_active_voltage_code,
	input wire logic o_linear_reg_discharge_on,
	input wire logic [6:0] o_linear_reg_voltage_code
);
	logic [2:0] live_q;
	logic [3:0] off_q;
	logic [7:0] ldo_q, lp_q, sw1_q, sw2_q, sw3_q;
	// ====
	// shadow copies of the registers behind the outputs
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			live_q <= 3'h0;
			ldo_q <= 8'ha8;
			lp_q <= 8'h37;
			sw1_q <= 8'h0d;
			sw2_q <= 8'h25;
			sw3_q <= 8'h20;
		end else begin
			if (live_q != 3'h4) live_q <= live_q + 3'h1;
			if (i_reg_wr) begin
				case (i_reg_addr)
					8'h36: ldo_q <= i_reg_wdata;
					8'h52: lp_q <= i_reg_wdata;
					8'h69: sw1_q <= i_reg_wdata;
					8'h6a: sw2_q <= i_reg_wdata;
					8'h6b: sw3_q <= i_reg_wdata;
					default: ;
				endcase
			end
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || i_linear_reg_on) off_q <= 4'h0;
		else if (off_q != 4'hf) off_q <= off_q + 4'h1;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// ====
	ldo_code_a: assert property (live_q == 3'h4 |-> o_linear_reg_voltage_code == $past(ldo_q[6:0]))
		else $error("linear regulator code differs from register");
	dis_enable_a: assert property (live_q == 3'h4 && o_linear_reg_discharge_on |-> $past(ldo_q[7]))
		else $error("discharge applied with enable bit clear");
	dis_off_a: assert property (off_q > 4'h5 && live_q == 3'h4 && $past(ldo_q[7]) |-> o_linear_reg_discharge_on)
		else $error("discharge missing while regulator off");
	gate_rate_a: assert property (live_q == 3'h4 |-> o_switch_gate_drive_rate == {$past(sw2_q[2:0]), $past(sw1_q[2:0])})
		else $error("gate drive rate differs from register");
	src3_sel_a: assert property (live_q == 3'h4 |-> o_switch_source[5:4] == ($past(sw3_q[5]) ? 2'b11 :
		($past(sw3_q[4]) ? 2'b10 : {1'b0, $past(sw3_q[3])})))
		else $error("switch three source decode wrong");
	lp_code_a: assert property (live_q == 3'h4 |-> o_conv3_active_voltage_code == $past(lp_q[6:0]))
		else $error("low power code differs from register");
	flag_blank_a: assert property ($past(i_reg_rd && i_reg_addr == 8'h03) |-> o_reg_rdata[7:3] == 5'h00)
		else $error("blank flag bits read nonzero");
	unmapped_rd_a: assert property ($past(i_reg_rd && i_reg_addr > 8'h6b) |-> o_reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	rd_hold_a: assert property (live_q == 3'h4 && !$past(i_reg_rd) |-> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	flag_rd_c: cover property ($past(i_reg_rd && i_reg_addr == 8'h03) && o_reg_rdata != 8'h00);
	dis_c: cover property (o_linear_reg_discharge_on);
	sw3_wr_c: cover property (i_reg_wr && i_reg_addr == 8'h6b);
endmodule : regs_checker
bind regulator_config_status_regs regs_checker i_chk (.i_core_clk, .i_rst_n, .i_reg_wr, .i_reg_rd,
	.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_linear_reg_on, .o_switch_source,
	.o_switch_gate_drive_rate, .o_conv3_active_voltage_code, .o_linear_reg_discharge_on,
	.o_linear_reg_voltage_code);

/* tb_top.sv */
/* self-checking bench for the regulator register bank.
   assumes the host model drives the bus and reads return one edge later. */
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr, rd, lin_on = 1'b1, lpm = 1'b0, rd_d = 1'b0, ldis, uselp;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] sw_on = 3'h0, uv = 3'h0, ovs, conv_on = 3'h7, ffe, cdis;
	logic [5:0] rej, thr, hys, src, gate;
	logic [6:0] lpc, ldoc;
	logic [7:0] exp_q[$];
	logic [7:0] wv[12];
	logic [7:0] adr[12] = '{8'h03, 8'h36, 8'h48, 8'h49, 8'h4c, 8'h4d, 8'h50, 8'h51, 8'h52, 8'h69, 8'h6a, 8'h6b};
	logic [7:0] rv[12] = '{8'h00, 8'ha8, 8'h06, 8'h09, 8'h06, 8'h09, 8'h06, 8'h09, 8'h37, 8'h0d, 8'h25, 8'h20};
	logic [7:0] msk[12] = '{8'h00, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h38};
	int fail_count = 0, samples_checked = 0, seed = 32'h6981, cyc = 0, i;
	always #2.5 clk = ~clk;
	host_bus_model i_host (.i_core_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
	regulator_config_status_regs i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_conv_on(conv_on), .i_switch_on(sw_on),
		.i_switch_undervolt(uv), .i_linear_reg_on(lin_on), .i_low_power_mode(lpm), .o_conv_discharge_on(cdis),
		.o_conv_fixed_freq_enable(ffe), .o_conv_brownout_reject_period(rej), .o_conv_overvolt_threshold_sel(ovs),
		.o_conv_brownout_threshold(thr), .o_conv_brownout_hysteresis(hys), .o_conv3_active_voltage_code(lpc),
		.o_conv3_use_low_power_code(uselp), .o_switch_source(src), .o_switch_gate_drive_rate(gate),
		.o_linear_reg_discharge_on(ldis), .o_linear_reg_voltage_code(ldoc));
	// ====
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.access(1'b0, a, 8'h00);
	endtask : rd_exp
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask : settle
	function automatic logic [1:0] srcf(input logic [7:0] v);
		return v[5] ? 2'b11 : (v[4] ? 2'b10 : {1'b0, v[3]});
	endfunction : srcf
	// ====
	// read results are matched against the oldest note
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d) chk(rdata, exp_q.pop_front());
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 12; i++) rd_exp(adr[i], rv[i]);
		rd_exp(8'hff, 8'h00);
		$display("test reset values done");
		wv[0] = 8'h00;
		for (i = 1; i < 12; i++) begin
			wv[i] = $random(seed) | 8'h01;
			if (i >= 9) wv[i] = wv[i] & 8'h3f;
			i_host.access(1'b1, adr[i], wv[i]);
		end
		i_host.access(1'b1, 8'h00, 8'hff);
		i_host.access(1'b1, 8'h03, 8'hff);
		for (i = 0; i < 12; i++) rd_exp(adr[i], wv[i] & msk[i]);
		rd_exp(8'h00, 8'h00);
		settle();
		chk({2'h0, gate}, {2'h0, wv[10][2:0], wv[9][2:0]});
		chk({1'b0, ldoc}, {1'b0, wv[1][6:0]});
		chk({1'b0, lpc}, {1'b0, wv[8][6:0]});
		chk({2'h0, src}, {2'h0, srcf(wv[11]), srcf(wv[10]), srcf(wv[9])});
		for (i = 0; i < 3; i++) begin
			chk({5'h0, ovs[i], rej[2*i+:2]}, {5'h0, wv[2+2*i][0], wv[2+2*i][2:1]});
			chk({4'h0, thr[2*i+:2], hys[2*i+:2]}, {4'h0, wv[3+2*i][3:0]});
			chk({7'h0, ffe[i]}, {7'h0, wv[2+2*i][3]});
		end
		chk({5'h0, cdis}, 8'h00);
		conv_on <= 3'h0;
		settle();
		chk({5'h0, cdis}, {5'h0, ~wv[7][3], ~wv[5][3], ~wv[3][3]});
		conv_on <= 3'h7;
		settle();
		chk({5'h0, cdis}, 8'h00);
		$display("test random writes done");
		for (i = 0; i < 8; i++) begin
			i_host.access(1'b1, 8'h6b, {2'h0, i[2:0], 3'h0});
			settle();
			chk({6'h0, src[5:4]}, {6'h0, srcf({2'h0, i[2:0], 3'h0})});
		end
		$display("test source codes done");
		i_host.access(1'b1, 8'h36, 8'h85);
		lin_on <= 1'b0;
		settle();
		chk({7'h0, ldis}, 8'h01);
		lin_on <= 1'b1;
		settle();
		chk({7'h0, ldis}, 8'h00);
		lin_on <= 1'b0;
		i_host.access(1'b1, 8'h36, 8'h05);
		settle();
		chk({7'h0, ldis}, 8'h00);
		$display("test discharge done");
		sw_on <= 3'b011;
		lpm <= 1'b1;
		settle();
		uv <= 3'b111;
		settle();
		uv <= 3'b000;
		settle();
		chk({7'h0, uselp}, 8'h01);
		rd_exp(8'h03, 8'h03);
		rd_exp(8'h03, 8'h00);
		uv <= 3'b111;
		settle();
		rd_exp(8'h03, 8'h03);
		rd_exp(8'h03, 8'h03);
		uv <= 3'b000;
		settle();
		rd_exp(8'h03, 8'h03);
		rd_exp(8'h03, 8'h00);
		$display("test undervoltage flags done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_exp(8'h36, 8'ha8);
		rd_exp(8'h6b, 8'h20);
		settle();
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : tb_top
